// >>> inc/vpic_pkg.sv
// Constants, types and helper functions shared by the vectored interrupt controller.
package vpic_pkg;

   localparam int NSRC = 32;
   localparam int SRC_W = 5;
   localparam int PRI_W = 3;
   localparam int TYPE_W = 2;
   localparam int STK_DEPTH = 8;
   localparam int STK_W = 4;
   localparam int DATA_W = 32;

   // Absolute bus addresses of the registers.
   localparam logic [31:0] ADDR_SMR_BASE = 32'hfffff000;
   localparam logic [31:0] ADDR_SVR_BASE = 32'hfffff080;
   localparam logic [31:0] ADDR_IVR = 32'hfffff100;
   localparam logic [31:0] ADDR_EOSC = 32'hfffff140;
   localparam logic [31:0] ADDR_SPU = 32'hfffff144;
   localparam logic [31:0] ADDR_CUR = 32'hfffff148;
   localparam logic [31:0] ADDR_REQ = 32'hfffff14c;
   localparam logic [31:0] ADDR_PEND = 32'hfffff150;

   // Source mode register layout.
   localparam int SMR_PRI_LSB = 0;
   localparam int SMR_TYPE_LSB = 5;
   localparam int TYPE_EDGE_BIT = 0;

   // Reset values.
   localparam logic [DATA_W-1:0] SPU_RST = 32'h00000000;
   localparam logic [DATA_W-1:0] SVR_RST = 32'h00000000;

   typedef struct packed {
      logic found;
      logic [SRC_W-1:0] src;
      logic [PRI_W-1:0] pri;
   } vpic_pick_t;

   typedef struct packed {
      logic [NSRC-1:0][PRI_W-1:0] pri;
      logic [NSRC-1:0][TYPE_W-1:0] styp;
      logic [DATA_W-1:0] spu;
      logic [STK_DEPTH-1:0][SRC_W-1:0] stk_src;
      logic [STK_DEPTH-1:0][PRI_W-1:0] stk_pri;
      logic [STK_W-1:0] depth;
      logic req;
      logic [NSRC-1:0] clr;
      logic [DATA_W-1:0] rdata;
      logic rd_mem;
      logic rvalid;
   } vpic_state_t;

   localparam vpic_state_t STATE_RST = '{spu: SPU_RST, default: '0};

   // Highest priority eligible source; strict compare keeps the lowest number on ties.
   function automatic vpic_pick_t pick_best(input logic [NSRC-1:0] elig,
                                            input logic [NSRC-1:0][PRI_W-1:0] pri);
      vpic_pick_t p;
      p = '0;
      for (int n = 1; n < NSRC; n++) begin
         if (elig[n] && (!p.found || pri[n] > p.pri)) begin
            p.found = 1'b1;
            p.src = SRC_W'(n);
            p.pri = pri[n];
         end
      end
      return p;
   endfunction

   // Decodes a 32-word window: bit 5 is the hit flag, bits 4:0 the word index.
   function automatic logic [SRC_W:0] win_index(input logic [31:0] addr,
                                                input logic [31:0] base);
      logic [31:0] d;
      d = addr - base;
      return {(d[31:7] == 25'h0) && (d[1:0] == 2'b00), d[6:2]};
   endfunction

endpackage

// >>> inc/vpic_mem_if.sv
// Connection between the controller and its vector memory.
interface vpic_mem_if #(
   parameter int AW = 5,
   parameter int DW = 32
);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic re;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;

   modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// >>> rtl/vpic_vec_mem.sv
// Handler address memory with registered read data.
module vpic_vec_mem #(
   parameter int AW = 5,
   parameter int DW = 32,
   parameter logic [DW-1:0] INIT = '0
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   vpic_mem_if.mem port
);

   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] word;
      logic [DW-1:0] rdata;
   } vpic_mem_state_t;

   vpic_mem_state_t s_r;
   vpic_mem_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (port.we) begin
         s_nxt.word[port.waddr] = port.wdata;
      end
      if (port.re) begin
         s_nxt.rdata = s_r.word[port.raddr];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '{word: {(1<<AW){INIT}}, rdata: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign port.rdata = s_r.rdata;

endmodule // vpic_vec_mem

// >>> rtl/vpic_ctrl.sv
// Vectored eight-level priority controller driving the normal interrupt request line.
//
// How it works
// - Normal request comes from sources 1 to 31, fast-forced sources excluded.
// - Each source has a three-bit priority, 7 most urgent, 0 least.
// - Outside a service, request rises once any eligible source has a pending condition.
// - Winner is chosen when the vector register is read, not when raised.
// - Equal top priority is resolved toward the smallest source number.
// - Current level equals the priority of the interrupt in service.
// - During a service only strictly higher priorities raise the request.
// - A higher priority arriving during a service re-raises the request.
// - Eight-entry stack holds source number and priority for nesting.
// - Vector read pushes the new current level and source.
// - Vector read returns the handler address of the selected source.
// - Vector read drops the request, even if the address is unused.
// - Vector read clears the selected source when it is edge-triggered.
// - End-of-service write pops the stack, restoring the previous level.
// - After the pop, anything above the restored level re-raises the request.
// - The vector register sits at absolute address 0xfffff100.
// - Pin routing adds no latency: pending inputs are read without resync.
// - Vector read never clears a fast-forced source.
// - Disabled sources take no part in selection.
// - Vector read with nothing eligible returns the spurious vector.
module vpic_ctrl (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [31:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic bus_rvalid,
   input wire logic [31:0] src_pending,
   input wire logic [31:0] src_enable,
   input wire logic [31:0] src_fast,
   output logic [31:0] src_clear,
   output logic [31:0] src_is_edge,
   output logic normal_req_n
);

   vpic_pkg::vpic_state_t s_r;
   vpic_pkg::vpic_state_t s_nxt;

   vpic_mem_if #(.AW(vpic_pkg::SRC_W), .DW(vpic_pkg::DATA_W)) vmem ();

   vpic_vec_mem #(
      .AW(vpic_pkg::SRC_W),
      .DW(vpic_pkg::DATA_W),
      .INIT(vpic_pkg::SVR_RST)
   ) u_vec_mem (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .port(vmem.mem)
   );

   logic [31:0] elig;
   vpic_pkg::vpic_pick_t pick;
   logic [vpic_pkg::STK_W-1:0] top;
   logic [vpic_pkg::PRI_W-1:0] cur_pri;
   logic [vpic_pkg::SRC_W-1:0] cur_src;
   logic in_service;
   logic above;
   logic [vpic_pkg::SRC_W:0] smr_hit;
   logic [vpic_pkg::SRC_W:0] svr_hit;
   logic ivr_rd;
   logic eos_wr;

   // Sources feeding the priority logic.
   always_comb begin
      elig = src_pending & src_enable & ~src_fast;
      elig[0] = 1'b0;
   end

   // Current level and the best eligible candidate.
   always_comb begin
      pick = vpic_pkg::pick_best(elig, s_r.pri);
      in_service = (s_r.depth != '0);
      top = s_r.depth - vpic_pkg::STK_W'(1);
      cur_pri = s_r.stk_pri[top[vpic_pkg::STK_W-2:0]];
      cur_src = s_r.stk_src[top[vpic_pkg::STK_W-2:0]];
      above = pick.found && (!in_service || pick.pri > cur_pri);
   end

   // Address decode.
   always_comb begin
      smr_hit = vpic_pkg::win_index(bus_addr, vpic_pkg::ADDR_SMR_BASE);
      svr_hit = vpic_pkg::win_index(bus_addr, vpic_pkg::ADDR_SVR_BASE);
      ivr_rd = bus_rd && (bus_addr == vpic_pkg::ADDR_IVR);
      eos_wr = bus_wr && (bus_addr == vpic_pkg::ADDR_EOSC);
   end

   // Next state.
   always_comb begin
      s_nxt = s_r;
      s_nxt.clr = '0;
      s_nxt.rvalid = bus_rd;
      s_nxt.rd_mem = 1'b0;
      s_nxt.rdata = '0;
      s_nxt.req = above;

      vmem.we = 1'b0;
      vmem.waddr = svr_hit[vpic_pkg::SRC_W-1:0];
      vmem.wdata = bus_wdata;
      vmem.re = 1'b0;
      vmem.raddr = svr_hit[vpic_pkg::SRC_W-1:0];

      if (bus_wr) begin
         if (smr_hit[vpic_pkg::SRC_W]) begin
            s_nxt.pri[smr_hit[vpic_pkg::SRC_W-1:0]] =
               bus_wdata[vpic_pkg::SMR_PRI_LSB +: vpic_pkg::PRI_W];
            s_nxt.styp[smr_hit[vpic_pkg::SRC_W-1:0]] =
               bus_wdata[vpic_pkg::SMR_TYPE_LSB +: vpic_pkg::TYPE_W];
         end
         if (svr_hit[vpic_pkg::SRC_W]) begin
            vmem.we = 1'b1;
         end
         if (bus_addr == vpic_pkg::ADDR_SPU) begin
            s_nxt.spu = bus_wdata;
         end
      end

      // Leaving a service restores the level underneath.
      if (eos_wr && in_service) begin
         s_nxt.depth = top;
      end

      if (bus_rd) begin
         if (ivr_rd) begin
            s_nxt.req = 1'b0;
            if (above && s_r.depth < vpic_pkg::STK_W'(vpic_pkg::STK_DEPTH)) begin
               s_nxt.stk_src[s_r.depth[vpic_pkg::STK_W-2:0]] = pick.src;
               s_nxt.stk_pri[s_r.depth[vpic_pkg::STK_W-2:0]] = pick.pri;
               s_nxt.depth = s_r.depth + vpic_pkg::STK_W'(1);
               vmem.re = 1'b1;
               vmem.raddr = pick.src;
               s_nxt.rd_mem = 1'b1;
               s_nxt.clr[pick.src] = s_r.styp[pick.src][vpic_pkg::TYPE_EDGE_BIT]
                                     && !src_fast[pick.src];
            end else begin
               s_nxt.rdata = s_r.spu;
            end
         end else if (smr_hit[vpic_pkg::SRC_W]) begin
            s_nxt.rdata[vpic_pkg::SMR_PRI_LSB +: vpic_pkg::PRI_W] =
               s_r.pri[smr_hit[vpic_pkg::SRC_W-1:0]];
            s_nxt.rdata[vpic_pkg::SMR_TYPE_LSB +: vpic_pkg::TYPE_W] =
               s_r.styp[smr_hit[vpic_pkg::SRC_W-1:0]];
         end else if (svr_hit[vpic_pkg::SRC_W]) begin
            vmem.re = 1'b1;
            s_nxt.rd_mem = 1'b1;
         end else if (bus_addr == vpic_pkg::ADDR_SPU) begin
            s_nxt.rdata = s_r.spu;
         end else if (bus_addr == vpic_pkg::ADDR_CUR) begin
            s_nxt.rdata[vpic_pkg::SRC_W-1:0] = in_service ? cur_src : '0;
         end else if (bus_addr == vpic_pkg::ADDR_REQ) begin
            s_nxt.rdata[0] = s_r.req;
         end else if (bus_addr == vpic_pkg::ADDR_PEND) begin
            s_nxt.rdata = elig;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= vpic_pkg::STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs.
   always_comb begin
      for (int n = 0; n < vpic_pkg::NSRC; n++) begin
         src_is_edge[n] = s_r.styp[n][vpic_pkg::TYPE_EDGE_BIT];
      end
   end

   assign bus_rdata = s_r.rd_mem ? vmem.rdata : s_r.rdata;
   assign bus_rvalid = s_r.rvalid;
   assign src_clear = s_r.clr;
   assign normal_req_n = ~s_r.req;

endmodule // vpic_ctrl

// >>> bench/vpic_ctrl_checker.sv
// Concurrent checks on the controller's request, read and clear ports.
module vpic_ctrl_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [31:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_rvalid,
   input wire logic [31:0] src_pending,
   input wire logic [31:0] src_enable,
   input wire logic [31:0] src_fast,
   input wire logic [31:0] src_clear,
   input wire logic [31:0] src_is_edge,
   input wire logic normal_req_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire logic [31:0] elig = src_pending & src_enable & ~src_fast & 32'hfffffffe;
   sequence s_vec_rd; bus_rd && bus_addr == vpic_pkg::ADDR_IVR; endsequence
   property p_ack; bus_rd |=> bus_rvalid; endproperty
   property p_quiet; !bus_rd |=> !bus_rvalid; endproperty
   property p_drop; s_vec_rd |=> normal_req_n; endproperty
   property p_idle; elig == 32'h0 |=> normal_req_n; endproperty
   property p_rise; $fell(normal_req_n) |-> $past(elig) != 32'h0; endproperty
   property p_clr_cause;
      src_clear != 32'h0 |-> $onehot(src_clear) && $past(bus_rd) &&
         $past(bus_addr) == vpic_pkg::ADDR_IVR;
   endproperty
   property p_clr_edge; (src_clear & ~src_is_edge) == 32'h0; endproperty
   property p_clr_fast; (src_clear & $past(src_fast)) == 32'h0; endproperty
   property p_clr_elig; (src_clear & ~$past(elig)) == 32'h0; endproperty
   property p_rst; $fell(sys_rst) |-> normal_req_n && !bus_rvalid; endproperty
   a_ack: assert property (p_ack) else $error("read got no answer");
   a_quiet: assert property (p_quiet) else $error("answer without read");
   a_drop: assert property (p_drop) else $error("request kept after vector read");
   a_idle: assert property (p_idle) else $error("request with nothing eligible");
   a_rise: assert property (p_rise) else $error("request without a cause");
   a_clr_cause: assert property (p_clr_cause) else $error("clear without vector read");
   a_clr_edge: assert property (p_clr_edge) else $error("clear of level source");
   a_clr_fast: assert property (p_clr_fast) else $error("clear of fast source");
   a_clr_elig: assert property (p_clr_elig) else $error("clear of ineligible source");
   a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // vpic_ctrl_checker
bind vpic_ctrl vpic_ctrl_checker i_chk (.core_clk, .sys_rst, .bus_addr, .bus_rd, .bus_rvalid,
   .src_pending, .src_enable, .src_fast, .src_clear, .src_is_edge, .normal_req_n);

// >>> bench/vpic_core_model.sv
// Processor-side bus master that fetches vectors and ends each service.
module vpic_core_model (
   input wire logic core_clk,
   input wire logic bus_rvalid,
   input wire logic [31:0] bus_rdata,
   output logic [31:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output logic [31:0] bus_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      bus_addr = 32'h0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 32'h0;
   end
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic v);
      @(negedge core_clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge core_clk);
      d = bus_rdata;
      v = bus_rvalid;
      bus_rd = 1'b0;
      bus_addr = ~a;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge core_clk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge core_clk);
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask
   task automatic eos();
      wr(vpic_pkg::ADDR_EOSC, 32'h0);
   endtask
endmodule // vpic_core_model

// >>> bench/vectored_priority_irq_controller_tb.sv
// Self-checking bench for the vectored priority controller.
module vectored_priority_irq_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] p, e, f; logic [4:0] w;} vpic_row_t;
   logic core_clk, sys_rst, normal_req_n, bus_rd, bus_wr, bus_rvalid;
   logic [31:0] pend, en, fast, bus_addr, bus_wdata, bus_rdata, src_clear, src_is_edge;
   int failures = 0;
   int check_count = 0;
   vpic_row_t rows[7] = '{'{32'h8, '1, 0, 3}, '{32'h8080, '1, 0, 7},
      '{32'h28, '1, 32'h20, 3}, '{32'h60, ~32'h40, 0, 5}, '{32'h1, '1, 0, 0},
      '{32'h100, '1, 0, 8}, '{0, '1, 0, 0}};
   vpic_ctrl i_dut (.core_clk, .sys_rst, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
      .bus_rvalid, .src_pending(pend), .src_enable(en), .src_fast(fast), .src_clear,
      .src_is_edge, .normal_req_n);
   vpic_core_model i_core (.core_clk, .bus_rvalid, .bus_rdata, .bus_addr, .bus_rd, .bus_wr,
      .bus_wdata);
   function automatic logic [31:0] vexp(input logic [4:0] s);
      return (s != 0) ? 32'h20000000 + {s, 2'b00} : 32'h00000ee0;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic w2();
      repeat (2) @(negedge core_clk);
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic v;
      i_core.rd(a, d, v);
      chkb("rvalid", 1'b1, v);
      chk("rdata", e, d);
   endtask
   task automatic vread(input logic [31:0] ev, input logic [31:0] ec);
      rdchk(vpic_pkg::ADDR_IVR, ev);
      chkb("req_n", 1'b1, normal_req_n);
      chk("clear", ec, src_clear);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      stop_test();
   end
   initial begin
      logic [4:0] s;
      sys_rst = 1'b1;
      pend = 32'h0;
      en = 32'h0;
      fast = 32'h0;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      rdchk(vpic_pkg::ADDR_SPU, 32'h0);
      for (int n = 0; n < 32; n++) begin
         s = 5'(n);
         i_core.wr(vpic_pkg::ADDR_SMR_BASE + {s, 2'b00}, {25'h0, 1'b0, s[0], 2'b00, s[2:0]});
         i_core.wr(vpic_pkg::ADDR_SVR_BASE + {s, 2'b00}, vexp(s));
      end
      i_core.wr(vpic_pkg::ADDR_SPU, 32'hee0);
      chk("edge", 32'haaaaaaaa, src_is_edge);
      rdchk(32'hfffff1f0, 32'h0);
      rdchk(vpic_pkg::ADDR_SMR_BASE + 32'h14, 32'h25);
      rdchk(vpic_pkg::ADDR_SVR_BASE + 32'h14, vexp(5));
      $display("setup done");
      foreach (rows[i]) begin
         pend = rows[i].p;
         en = rows[i].e;
         fast = rows[i].f;
         w2();
         chkb("req_n", rows[i].w == 0, normal_req_n);
         vread(vexp(rows[i].w), rows[i].w[0] ? 32'h1 << rows[i].w : 32'h0);
         i_core.eos();
         $display("row %0d done", i);
      end
      pend = 32'h8;
      w2();
      vread(vexp(3), 32'h8);
      pend = 32'hc;
      w2();
      chkb("req_n", 1'b1, normal_req_n);
      pend = 32'h4c;
      w2();
      chkb("req_n", 1'b0, normal_req_n);
      vread(vexp(6), 32'h0);
      rdchk(vpic_pkg::ADDR_CUR, 32'h6);
      pend = 32'h1c;
      w2();
      chkb("req_n", 1'b1, normal_req_n);
      i_core.eos();
      w2();
      chkb("req_n", 1'b0, normal_req_n);
      rdchk(vpic_pkg::ADDR_REQ, 32'h1);
      rdchk(vpic_pkg::ADDR_PEND, 32'h1c);
      vread(vexp(4), 32'h0);
      repeat (3) i_core.eos();
      pend = 32'h0;
      $display("nesting done");
      for (int k = 0; k < 8; k++) begin
         s = (k == 0) ? 5'd8 : 5'(k);
         pend = pend | (32'h1 << s);
         w2();
         chkb("req_n", 1'b0, normal_req_n);
         vread(vexp(s), s[0] ? 32'h1 << s : 32'h0);
      end
      vread(32'hee0, 32'h0);
      repeat (8) i_core.eos();
      w2();
      chkb("req_n", 1'b0, normal_req_n);
      $display("stack done");
      sys_rst = 1'b1;
      @(negedge core_clk);
      chkb("req_n", 1'b1, normal_req_n);
      chkb("rvalid", 1'b0, bus_rvalid);
      chk("edge", 32'h0, src_is_edge);
      sys_rst = 1'b0;
      w2();
      chkb("req_n", 1'b0, normal_req_n);
      vread(32'h0, 32'h0);
      $display("reset done");
      stop_test();
   end
endmodule // vectored_priority_irq_controller_tb
